// >>> core/ofd_map.svh
`ifndef OFD_MAP_SVH
`define OFD_MAP_SVH
`define OFD_ESC_NIB 4'hE
`define OFD_LONG_MASK 16'h011F
`define OFD_NUM_FMT 4'hA
`define OFD_SHORT_LEN 16'h0002
`define OFD_BIT_HI 6
`define OFD_BIT_LO 4
`define OFD_POL_POS 7
`define OFD_CC_HI 7
`define OFD_CC_LO 4
`define OFD_EXT_LO_HI 7
`define OFD_EXT_LO_LO 4
`endif

// >>> core/ofd_pkg.sv
package ofd_pkg;
  typedef enum logic [3:0] {
    OFD_F_ADD = 4'h0,
    OFD_F_BIT = 4'h1,
    OFD_F_DIR = 4'h2,
    OFD_F_EXT = 4'h3,
    OFD_F_LIT = 4'h4,
    OFD_F_PAIR = 4'h5,
    OFD_F_IND = 4'h6,
    OFD_F_REL = 4'h7,
    OFD_F_IDX = 4'h8,
    OFD_F_VEC = 4'h9
  } ofd_fmt_t;

  typedef enum logic [2:0] {
    OFD_ST_OPC = 3'h1,
    OFD_ST_B1 = 3'h2,
    OFD_ST_B2 = 3'h4
  } ofd_state_t;

  typedef struct packed {
    ofd_state_t state;
    ofd_fmt_t fmt;
    logic [7:0] opc;
    logic [7:0] b1;
    logic [15:0] pc;
  } ofd_regs_t;
endpackage

// >>> core/ofd_field_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "ofd_map.svh"
module ofd_field_unit (
  // Instruction bytes, format and address
  input wire ofd_pkg::ofd_fmt_t fmt,
  input wire logic [7:0] opc,
  input wire logic [7:0] b1,
  input wire logic [7:0] b2,
  input wire logic [15:0] pc,
  // Register operands
  output logic [7:0] src_addr,
  output logic src_work,
  output logic [3:0] src_slot,
  output logic [7:0] dst_addr,
  output logic dst_work,
  output logic [3:0] dst_slot,
  // Other fields
  output logic [2:0] bit_index,
  output logic polarity,
  output logic [15:0] direct_target_word,
  output logic [11:0] twelve_bit_file_address,
  output logic [7:0] literal_byte,
  output logic pair_is_work,
  output logic [3:0] work_pair,
  output logic [7:0] file_pair,
  output logic pair_err,
  output logic ptr_is_work,
  output logic [3:0] ptr_work_slot,
  output logic [7:0] ptr_file_slot,
  output logic [15:0] jump_displacement,
  output logic [15:0] jump_target,
  output logic [15:0] index_offset,
  output logic [7:0] indexed_file_addr,
  output logic [7:0] vector_addr,
  output logic [3:0] cond_code
);
  import ofd_pkg::*;

  // ----------------------------------------
  // Register operand decode
  // ----------------------------------------
  assign src_addr = b1; // [RULE1]
  assign dst_addr = (fmt == OFD_F_LIT) ? b1 : b2; // [RULE1]
  assign src_work = (b1[7:4] == `OFD_ESC_NIB); // [RULE2]
  assign src_slot = b1[3:0]; // [RULE2]
  assign dst_work = (dst_addr[7:4] == `OFD_ESC_NIB); // [RULE2]
  assign dst_slot = dst_addr[3:0]; // [RULE2]

  // ----------------------------------------
  // Field extraction
  // ----------------------------------------
  assign bit_index = b1[`OFD_BIT_HI:`OFD_BIT_LO]; // [RULE3]
  assign polarity = b1[`OFD_POL_POS]; // [RULE13]
  assign direct_target_word = {b1, b2}; // [RULE4]
  assign twelve_bit_file_address = {b1, b2[`OFD_EXT_LO_HI:`OFD_EXT_LO_LO]}; // [RULE5]
  assign literal_byte = b2; // [RULE6]
  assign pair_is_work = (b1[7:4] == `OFD_ESC_NIB); // [RULE7]
  assign work_pair = b1[3:0]; // [RULE7]
  assign file_pair = b1; // [RULE8]
  assign pair_err = (fmt == OFD_F_PAIR) && b1[0]; // [RULE7] [RULE8]
  assign ptr_is_work = (b1[7:4] == `OFD_ESC_NIB); // [RULE11]
  assign ptr_work_slot = b1[3:0]; // [RULE11]
  assign ptr_file_slot = b1; // [RULE11]
  assign jump_displacement = {{8{b1[7]}}, b1}; // [RULE9]
  assign jump_target = 16'(pc + `OFD_SHORT_LEN + jump_displacement); // [RULE9]
  assign index_offset = {{8{b2[7]}}, b2}; // [RULE10]
  assign indexed_file_addr = 8'(b1 + b2); // [RULE10]
  assign vector_addr = b1; // [RULE12]
  assign cond_code = opc[`OFD_CC_HI:`OFD_CC_LO]; // [RULE15]
endmodule
`default_nettype wire

// >>> core/ofd_decoder.sv
// Function
// [RULE1] Add opcode: first operand byte is source, second is destination.
// [RULE2] Register byte with high nibble E selects working register of low nibble.
// [RULE3] Bit number is a three-bit field, positions zero to seven.
// [RULE4] Direct address is a full 16-bit program address.
// [RULE5] Extended register operand is a 12-bit register file address.
// [RULE6] Immediate operand is one literal data byte.
// [RULE7] Working register pair index must be even, zero to fourteen.
// [RULE8] Register pair address must be an even byte value.
// [RULE9] Relative byte sign-extended and added to next instruction address.
// [RULE10] Indexed mode offsets register by a signed index byte.
// [RULE11] Indirect register operand is an 8-bit address of the pointer.
// [RULE12] Vector operand is an 8-bit vector address.
// [RULE13] Polarity operand is a single bit choosing one of two polarities.
// [RULE14] Add combines source and destination, result written to destination.
// [RULE15] Condition code comes from opcode bits seven down to four.
// [RULE16] Fields presented in the cycle the last instruction byte is accepted.
`timescale 1ns/1ps
`default_nettype none
`include "ofd_map.svh"
module ofd_decoder (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fetch side
  input wire logic f_valid,
  input wire logic [7:0] f_byte,
  input wire ofd_pkg::ofd_fmt_t f_fmt,
  input wire logic [15:0] f_pc,
  output logic f_ready,
  // Execute side
  input wire logic x_ready,
  output logic x_valid,
  output ofd_pkg::ofd_fmt_t x_fmt,
  output logic x_err,
  // Register operands
  output logic [7:0] src_addr,
  output logic src_work,
  output logic [3:0] src_slot,
  output logic [7:0] dst_addr,
  output logic dst_work,
  output logic [3:0] dst_slot,
  // Other fields
  output logic [2:0] bit_index,
  output logic polarity,
  output logic [15:0] direct_target_word,
  output logic [11:0] twelve_bit_file_address,
  output logic [7:0] literal_byte,
  output logic pair_is_work,
  output logic [3:0] work_pair,
  output logic [7:0] file_pair,
  output logic ptr_is_work,
  output logic [3:0] ptr_work_slot,
  output logic [7:0] ptr_file_slot,
  output logic [15:0] jump_displacement,
  output logic [15:0] jump_target,
  output logic [15:0] index_offset,
  output logic [7:0] indexed_file_addr,
  output logic [7:0] vector_addr,
  output logic [3:0] cond_code,
  // Add datapath
  input wire logic [7:0] src_data,
  input wire logic [7:0] dst_data,
  output logic [7:0] add_result,
  output logic wb_en,
  output logic [7:0] wb_addr,
  output logic wb_work
);
  import ofd_pkg::*;

  localparam logic [15:0] LONG_MASK = `OFD_LONG_MASK;

  ofd_regs_t st_ff;
  ofd_regs_t nxt_st;
  logic long_fmt;
  logic last_phase;
  logic take;
  logic pair_err;
  logic [7:0] b1_now;

  // ----------------------------------------
  // Byte sequencing
  // ----------------------------------------
  assign long_fmt = LONG_MASK[st_ff.fmt];
  assign last_phase = (st_ff.state == OFD_ST_B2) || ((st_ff.state == OFD_ST_B1) && !long_fmt);
  assign take = f_valid && f_ready;
  assign b1_now = (st_ff.state == OFD_ST_B1) ? f_byte : st_ff.b1;

  always_comb begin
    nxt_st = st_ff;
    f_ready = !last_phase || x_ready;
    x_valid = take && last_phase; // [RULE16]
    unique case (st_ff.state)
      OFD_ST_OPC: begin
        if (take) begin
          nxt_st.fmt = f_fmt;
          nxt_st.opc = f_byte;
          nxt_st.pc = f_pc;
          nxt_st.state = OFD_ST_B1;
        end
      end
      OFD_ST_B1: begin
        if (take) begin
          nxt_st.b1 = f_byte;
          nxt_st.state = long_fmt ? OFD_ST_B2 : OFD_ST_OPC;
        end
      end
      OFD_ST_B2: begin
        if (take) begin
          nxt_st.state = OFD_ST_OPC;
        end
      end
      default: begin
        nxt_st.state = OFD_ST_OPC;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '{state: OFD_ST_OPC, fmt: OFD_F_ADD, opc: 8'h00, b1: 8'h00, pc: 16'h0000};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // Field extraction
  // ----------------------------------------
  ofd_field_unit u_fields (
    .fmt(st_ff.fmt),
    .opc(st_ff.opc),
    .b1(b1_now),
    .b2(f_byte),
    .pc(st_ff.pc),
    .src_addr(src_addr),
    .src_work(src_work),
    .src_slot(src_slot),
    .dst_addr(dst_addr),
    .dst_work(dst_work),
    .dst_slot(dst_slot),
    .bit_index(bit_index),
    .polarity(polarity),
    .direct_target_word(direct_target_word),
    .twelve_bit_file_address(twelve_bit_file_address),
    .literal_byte(literal_byte),
    .pair_is_work(pair_is_work),
    .work_pair(work_pair),
    .file_pair(file_pair),
    .pair_err(pair_err),
    .ptr_is_work(ptr_is_work),
    .ptr_work_slot(ptr_work_slot),
    .ptr_file_slot(ptr_file_slot),
    .jump_displacement(jump_displacement),
    .jump_target(jump_target),
    .index_offset(index_offset),
    .indexed_file_addr(indexed_file_addr),
    .vector_addr(vector_addr),
    .cond_code(cond_code)
  );

  assign x_fmt = st_ff.fmt;
  assign x_err = x_valid && ((st_ff.fmt >= `OFD_NUM_FMT) || pair_err); // [RULE7] [RULE8]

  // ----------------------------------------
  // Add and write back
  // ----------------------------------------
  assign add_result = 8'(src_data + dst_data); // [RULE14]
  assign wb_en = x_valid && (st_ff.fmt == OFD_F_ADD); // [RULE14]
  assign wb_addr = dst_addr; // [RULE14]
  assign wb_work = dst_work;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [7:0] h_prev_ff;
  logic [7:0] h_opc_ff;
  logic [15:0] h_pc_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      h_prev_ff <= 8'h00;
      h_opc_ff <= 8'h00;
      h_pc_ff <= 16'h0000;
    end else if (take) begin
      h_prev_ff <= f_byte;
      if (st_ff.state == OFD_ST_OPC) begin
        h_opc_ff <= f_byte;
        h_pc_ff <= f_pc;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_last_take;
    x_valid && f_valid && f_ready && (st_ff.state != OFD_ST_OPC);
  endsequence

  sequence s_back_idle;
    st_ff.state == OFD_ST_OPC;
  endsequence

  a_last_byte_out: assert property (x_valid |-> s_last_take ##1 s_back_idle) // [RULE16]
    else $error("fields not presented on last byte");

  a_add_order: assert property ( // [RULE1]
    (x_valid && x_fmt == OFD_F_ADD) |-> (src_addr == h_prev_ff) && (dst_addr == f_byte))
    else $error("add operand order wrong");

  a_escape_work: assert property ( // [RULE2]
    (x_valid && x_fmt == OFD_F_ADD && h_prev_ff[7:4] == 4'hE) |-> src_work && (src_slot == h_prev_ff[3:0]))
    else $error("escaped register not decoded");

  a_bit_field: assert property ((x_valid && x_fmt == OFD_F_BIT) |-> bit_index == h_prev_ff[6:4]) // [RULE3]
    else $error("bit index wrong");

  a_direct_word: assert property ( // [RULE4]
    (x_valid && x_fmt == OFD_F_DIR) |-> direct_target_word == {h_prev_ff, f_byte})
    else $error("direct address wrong");

  a_ext_addr: assert property ( // [RULE5]
    (x_valid && x_fmt == OFD_F_EXT) |-> twelve_bit_file_address == {h_prev_ff, f_byte[7:4]})
    else $error("extended address wrong");

  a_pair_even: assert property ( // [RULE8]
    (x_valid && x_fmt == OFD_F_PAIR && !x_err) |-> !file_pair[0] && !work_pair[0])
    else $error("odd pair accepted");

  a_rel_target: assert property ( // [RULE9]
    (x_valid && x_fmt == OFD_F_REL) |-> jump_target == 16'(h_pc_ff + `OFD_SHORT_LEN + {{8{f_byte[7]}}, f_byte}))
    else $error("relative target wrong");

  a_cc_field: assert property (x_valid |-> cond_code == h_opc_ff[7:4]) // [RULE15]
    else $error("condition code wrong");

  a_add_wb: assert property ( // [RULE14]
    wb_en |-> (add_result == 8'(src_data + dst_data)) && (wb_addr == f_byte) && (x_fmt == OFD_F_ADD))
    else $error("add write back wrong");
endmodule
`default_nettype wire

// >>> verif/ofd_exec_model.sv
`timescale 1ns/1ps
`default_nettype none
module ofd_exec_model (
  // Clock and stall control
  input wire logic clk,
  input wire logic stall,
  // Decoder side
  input wire logic [7:0] src_addr,
  input wire logic [7:0] dst_addr,
  input wire logic wb_en,
  input wire logic [7:0] wb_addr,
  input wire logic [7:0] add_result,
  output logic x_ready,
  output logic [7:0] src_data,
  output logic [7:0] dst_data
);
  logic [7:0] mem [256];
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
  end
  assign x_ready = !stall;
  assign src_data = mem[src_addr];
  assign dst_data = mem[dst_addr];
  // Result lands in destination
  always @(posedge clk) begin
    if (wb_en) mem[wb_addr] <= add_result;
  end
endmodule
`default_nettype wire

// >>> verif/operand_field_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, e); end end
module operand_field_decoder_tb;
  import ofd_pkg::*;
  logic clk = 0, rst = 1, f_valid = 0, stall = 0;
  logic [7:0] f_byte = 8'h00;
  logic [15:0] f_pc = 16'h0000;
  ofd_fmt_t f_fmt = OFD_F_ADD;
  ofd_fmt_t x_fmt;
  logic f_ready, x_ready, x_valid, x_err, src_work, dst_work, polarity, pair_is_work, ptr_is_work, wb_en, wb_work;
  logic [7:0] src_addr, dst_addr, literal_byte, file_pair, ptr_file_slot, indexed_file_addr, vector_addr;
  logic [7:0] src_data, dst_data, add_result, wb_addr;
  logic [3:0] src_slot, dst_slot, work_pair, ptr_work_slot, cond_code;
  logic [2:0] bit_index;
  logic [15:0] direct_target_word, jump_displacement, jump_target, index_offset;
  logic [11:0] twelve_bit_file_address;
  int miscompares = 0, n_checks = 0, cyc = 0;
  always #4 clk = ~clk;
  ofd_decoder u_dut (.clk(clk), .rst(rst), .f_valid(f_valid), .f_byte(f_byte), .f_fmt(f_fmt), .f_pc(f_pc),
    .f_ready(f_ready), .x_ready(x_ready), .x_valid(x_valid), .x_fmt(x_fmt), .x_err(x_err),
    .src_addr(src_addr), .src_work(src_work), .src_slot(src_slot), .dst_addr(dst_addr), .dst_work(dst_work),
    .dst_slot(dst_slot), .bit_index(bit_index), .polarity(polarity), .direct_target_word(direct_target_word),
    .twelve_bit_file_address(twelve_bit_file_address), .literal_byte(literal_byte), .pair_is_work(pair_is_work),
    .work_pair(work_pair), .file_pair(file_pair), .ptr_is_work(ptr_is_work), .ptr_work_slot(ptr_work_slot),
    .ptr_file_slot(ptr_file_slot), .jump_displacement(jump_displacement), .jump_target(jump_target),
    .index_offset(index_offset), .indexed_file_addr(indexed_file_addr), .vector_addr(vector_addr),
    .cond_code(cond_code), .src_data(src_data), .dst_data(dst_data), .add_result(add_result), .wb_en(wb_en),
    .wb_addr(wb_addr), .wb_work(wb_work));
  ofd_exec_model u_model (.clk(clk), .stall(stall), .src_addr(src_addr), .dst_addr(dst_addr), .wb_en(wb_en),
    .wb_addr(wb_addr), .add_result(add_result), .x_ready(x_ready), .src_data(src_data), .dst_data(dst_data));
  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic issue(input ofd_fmt_t fm, input logic [7:0] opc, b1, b2, input int hold);
    logic [7:0] q [$];
    int n;
    q = {opc, b1};
    if (fm inside {OFD_F_ADD, OFD_F_BIT, OFD_F_DIR, OFD_F_EXT, OFD_F_LIT, OFD_F_IDX}) q.push_back(b2);
    foreach (q[i]) begin
      @(negedge clk);
      f_valid = 1'b1;
      f_byte = q[i];
      f_fmt = fm;
      f_pc = 16'h1000;
      if (i == q.size() - 1 && hold > 0) begin
        stall = 1'b1;
        #1;
        `CHK({f_ready, x_valid}, 2'b00)
        repeat (hold) @(negedge clk);
        stall = 1'b0;
      end
      #1;
      n = 0;
      while (f_ready !== 1'b1 && n < 20) begin
        @(negedge clk);
        #1;
        n++;
      end
    end
    `CHK(x_valid, 1'b1)
  endtask
  task automatic idle;
    @(negedge clk);
    f_valid = 1'b0;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_add;
    issue(OFD_F_ADD, 8'h04, 8'hE8, 8'h43, 0);
    `CHK({src_work, src_slot, dst_work, dst_addr}, {1'b1, 4'h8, 1'b0, 8'h43})
    `CHK({wb_en, wb_addr, add_result}, {1'b1, 8'h43, 8'hCB})
    `CHK({x_fmt, wb_work, dst_slot}, {OFD_F_ADD, 1'b0, 4'h3})
    `CHK(cond_code, 4'h0)
    idle();
    `CHK(u_model.mem[8'h43], 8'hCB)
    issue(OFD_F_ADD, 8'h04, 8'h43, 8'hE8, 0);
    `CHK({src_work, dst_work, dst_slot, wb_work, add_result}, {1'b0, 1'b1, 4'h8, 1'b1, 8'h7D})
    idle();
  endtask
  task automatic t_fields;
    issue(OFD_F_DIR, 8'hD6, 8'h12, 8'h34, 0);
    `CHK(direct_target_word, 16'h1234)
    idle();
    issue(OFD_F_EXT, 8'h08, 8'hAB, 8'hC5, 0);
    `CHK(twelve_bit_file_address, 12'hABC)
    idle();
    issue(OFD_F_BIT, 8'hE2, 8'hF0, 8'h43, 0);
    `CHK({polarity, bit_index}, 4'hF)
    idle();
    issue(OFD_F_LIT, 8'h06, 8'h43, 8'hFF, 0);
    `CHK({dst_addr, literal_byte}, 16'h43FF)
    idle();
    issue(OFD_F_IDX, 8'h87, 8'h10, 8'h80, 0);
    `CHK({index_offset, indexed_file_addr}, 24'hFF8090)
    idle();
  endtask
  task automatic t_jump;
    issue(OFD_F_REL, 8'hB8, 8'h80, 8'h00, 0);
    `CHK({jump_displacement, jump_target, cond_code}, {16'hFF80, 16'h0F82, 4'hB})
    idle();
    issue(OFD_F_REL, 8'h08, 8'h7F, 8'h00, 0);
    `CHK(jump_target, 16'h1081)
    idle();
  endtask
  task automatic t_pair;
    logic [7:0] pb [4] = '{8'hE4, 8'hE5, 8'h43, 8'hFE};
    foreach (pb[i]) begin
      issue(OFD_F_PAIR, 8'h12, pb[i], 8'h00, 0);
      `CHK(x_err, pb[i][0])
      `CHK(pair_is_work, pb[i][7:4] == 4'hE)
      if (pb[i][7:4] == 4'hE) `CHK(work_pair, pb[i][3:0])
      else `CHK(file_pair, pb[i])
      idle();
    end
  endtask
  task automatic t_ptr_vec;
    issue(OFD_F_IND, 8'h72, 8'hE5, 8'h00, 0);
    `CHK({ptr_is_work, ptr_work_slot}, 5'h15)
    idle();
    issue(OFD_F_IND, 8'h72, 8'h7F, 8'h00, 0);
    `CHK({ptr_is_work, ptr_file_slot}, 9'h07F)
    idle();
    issue(OFD_F_VEC, 8'hAF, 8'hFF, 8'h00, 3);
    `CHK(vector_addr, 8'hFF)
    idle();
  endtask
  task automatic t_reset;
    @(negedge clk);
    f_valid = 1'b1;
    f_byte = 8'h04;
    f_fmt = OFD_F_ADD;
    @(negedge clk);
    f_byte = 8'hE8;
    @(negedge clk);
    f_byte = 8'h43;
    rst = 1'b1;
    #1;
    `CHK({f_ready, x_valid, wb_en}, 3'b100)
    @(negedge clk);
    rst = 1'b0;
    f_valid = 1'b0;
    issue(OFD_F_REL, 8'hF8, 8'h02, 8'h00, 0);
    `CHK({x_fmt, jump_target, cond_code}, {OFD_F_REL, 16'h1004, 4'hF})
    idle();
  endtask
  task automatic summarize;
    if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_add();
    t_fields();
    t_jump();
    t_pair();
    t_ptr_vec();
    t_reset();
    summarize();
  end
endmodule
`default_nettype wire
